// ==== verilog/mipu_core.sv ====
// Interrupt priority, entry stacking, vector fetch and return sequencer
`timescale 1ns/100ps

// How it works
// - Interrupts start only at instruction boundaries
// - Entry pushes CPU registers before service
// - Program counter loaded from winning vector pair
// - Fixed priority: reset, external, timers, serial, analog
// - No preemption unless service cleared mask
// - Entry sets the global mask bit
// - Return restores registers in reverse order
// - Soft trap ignores masks, own vector
// - Port A pins join external only optioned
// - External blocked by mask or enable clear
// - Watchdog reset only when option enables it
// - External latch cleared during vector fetch
// - Pin falling edge, optionally plus low level
// - Port A rising edge latches external request
module mipu_core
  import mipu_pkg::*;
(
  input wire logic MCLK, // System clock
  input wire logic RESET, // Synchronous reset
  input wire logic INSTR_DONE, // Current instruction finished
  input wire logic SOFT_TRAP_INSTR, // Soft trap instruction at boundary
  input wire logic RETURN_FROM_TRAP_INSTR, // Return from trap at boundary
  input wire mipu_regs_t CPU_REGS, // Live CPU registers
  input wire mipu_flags_t PERIPH_FLAGS, // Peripheral flags
  input wire mipu_enables_t PERIPH_ENABLES, // Peripheral enables
  input wire logic IRQ_PIN_N, // External interrupt pin
  input wire logic [3:0] PORT_A_IRQ_PINS, // Port A interrupt pins
  input wire logic EXT_IRQ_ENABLE, // External enable bit
  input wire logic EXT_FLAG_CLEAR, // Software clear of external latch
  input wire logic PORT_IRQ_OPTION, // Port A interrupt option
  input wire logic LEVEL_SENSE_OPTION, // Edge plus level option
  input wire logic WATCHDOG_OPTION, // Watchdog enable option
  input wire logic WATCHDOG_TIMEOUT, // Watchdog expiry pulse
  input wire logic RESET_REQ, // Other reset sources
  input wire logic [7:0] MEM_RDATA, // Read data, one cycle after read
  output logic [15:0] MEM_ADDR, // Memory address
  output logic MEM_RD, // Memory read strobe
  output logic MEM_WR, // Memory write strobe
  output logic [7:0] MEM_WDATA, // Memory write data
  output logic BUSY, // Sequencer owns the CPU
  output logic ENTRY_LOAD, // Load pc, ccr, sp from REGS_OUT
  output logic RETURN_LOAD, // Load all of REGS_OUT
  output mipu_regs_t REGS_OUT, // Registers for the CPU
  output logic EXT_IRQ_FLAG // External latch state
);

  mipu_state_t st_ff;
  mipu_src_t src_ff;
  mipu_src_t nxt_src;
  logic [7:0] stk_ff [0:4];
  logic [2:0] idx_ff;
  logic [7:0] sp_ff;
  logic [7:0] vec_hi_ff;
  logic rd_pend_ff;
  logic [2:0] rd_idx_ff;
  logic [15:0] vec_addr;
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_st_ff;
  logic ext_level, ext_level_d_ff, ext_set, ext_latch_ff;
  logic i_bit, rst_req, ext_req, ctim_req, ptim_req, ser_req, ana_req, any_req;
  logic entry_load_ff, return_load_ff;
  mipu_regs_t regs_out_ff;

  // Raw pins in synchroniser order, external pin at bit 0
  assign pin_raw = {PORT_A_IRQ_PINS, IRQ_PIN_N};

  // Three-stage synchronisers; a change is taken once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_pin
      always_ff @(posedge MCLK) begin
        if (RESET) begin
          pin_s1_ff[g] <= MIPU_PIN_IDLE[g];
          pin_s2_ff[g] <= MIPU_PIN_IDLE[g];
          pin_s3_ff[g] <= MIPU_PIN_IDLE[g];
          pin_st_ff[g] <= MIPU_PIN_IDLE[g];
        end else begin
          pin_s1_ff[g] <= pin_raw[g];
          pin_s2_ff[g] <= pin_s1_ff[g];
          pin_s3_ff[g] <= pin_s2_ff[g];
          if (pin_s2_ff[g] == pin_s3_ff[g]) begin
            pin_st_ff[g] <= pin_s3_ff[g];
          end
        end
      end
    end
  endgenerate

  // port pins join only when optioned
  // Combined wired-OR request: a high port pin masks pin changes until all drop
  assign ext_level = ~pin_st_ff[0] | (PORT_IRQ_OPTION & (|pin_st_ff[4:1]));
  // edge or, by option, level too
  assign ext_set = (ext_level & ~ext_level_d_ff) | (LEVEL_SENSE_OPTION & ext_level);

  // latch cleared at vector fetch
  // Set wins over either clear so a request in the clear cycle is kept
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ext_level_d_ff <= 1'b0;
      ext_latch_ff <= 1'b0;
    end else begin
      ext_level_d_ff <= ext_level;
      if (ext_set) begin
        ext_latch_ff <= 1'b1;
      end else if (EXT_FLAG_CLEAR || (st_ff == MIPU_S_VEC_HI && src_ff == MIPU_SRC_EXT)) begin
        ext_latch_ff <= 1'b0;
      end
    end
  end
  assign EXT_IRQ_FLAG = ext_latch_ff;

  assign rst_req = RESET_REQ | (WATCHDOG_TIMEOUT & WATCHDOG_OPTION);
  // running service stays masked until it clears the mask
  assign i_bit = CPU_REGS.ccr[MIPU_CCR_I_POS];
  // external needs enable and clear mask
  assign ext_req = ext_latch_ff & EXT_IRQ_ENABLE & ~i_bit;
  assign ctim_req = ~i_bit & (
    (PERIPH_FLAGS.core_timer_overflow_flag & PERIPH_ENABLES.core_overflow_enable) |
    (PERIPH_FLAGS.periodic_tick_flag & PERIPH_ENABLES.periodic_tick_enable));
  assign ptim_req = ~i_bit & (
    (PERIPH_FLAGS.capture_flag & PERIPH_ENABLES.capture_irq_enable) |
    (PERIPH_FLAGS.compare_flag & PERIPH_ENABLES.compare_irq_enable) |
    (PERIPH_FLAGS.timer_overflow_flag & PERIPH_ENABLES.timer_overflow_enable));
  assign ser_req = ~i_bit & PERIPH_FLAGS.serial_done_flag & PERIPH_ENABLES.serial_irq_enable;
  assign ana_req = ~i_bit & PERIPH_ENABLES.comparator_irq_enable &
    (PERIPH_FLAGS.comparator1_flag | PERIPH_FLAGS.comparator2_flag);
  assign any_req = ext_req | ctim_req | ptim_req | ser_req | ana_req;

  // fixed priority winner select
  // Soft trap is the instruction itself, so it outranks hardware sources
  always_comb begin
    if (SOFT_TRAP_INSTR) begin
      nxt_src = MIPU_SRC_SOFT_TRAP;
    end else if (ext_req) begin
      nxt_src = MIPU_SRC_EXT;
    end else if (ctim_req) begin
      nxt_src = MIPU_SRC_CTIM;
    end else if (ptim_req) begin
      nxt_src = MIPU_SRC_PTIM;
    end else if (ser_req) begin
      nxt_src = MIPU_SRC_SER;
    end else begin
      nxt_src = MIPU_SRC_ANA;
    end
  end

  always_comb begin
    case (src_ff)
      MIPU_SRC_RESET: vec_addr = MIPU_VEC_RESET;
      MIPU_SRC_SOFT_TRAP: vec_addr = MIPU_VEC_SOFT_TRAP;
      MIPU_SRC_EXT: vec_addr = MIPU_VEC_EXT;
      MIPU_SRC_CTIM: vec_addr = MIPU_VEC_CTIM;
      MIPU_SRC_PTIM: vec_addr = MIPU_VEC_PTIM;
      MIPU_SRC_SER: vec_addr = MIPU_VEC_SER;
      default: vec_addr = MIPU_VEC_ANA;
    endcase
  end

  // Sequencer; reset sources abort anything, since a reset restarts the core
  always_ff @(posedge MCLK) begin
    if (RESET || rst_req) begin
      st_ff <= MIPU_S_VEC_HI;
      src_ff <= MIPU_SRC_RESET;
      idx_ff <= 3'h0;
    end else begin
      case (st_ff)
        MIPU_S_IDLE: begin
          idx_ff <= 3'h0;
          if (INSTR_DONE && RETURN_FROM_TRAP_INSTR) begin
            st_ff <= MIPU_S_POP;
          end else if (INSTR_DONE && (SOFT_TRAP_INSTR || any_req)) begin
            st_ff <= MIPU_S_PUSH;
            src_ff <= nxt_src;
          end
        end
        MIPU_S_PUSH: begin
          idx_ff <= idx_ff + 3'h1;
          if (idx_ff == MIPU_STK_LAST) begin
            st_ff <= MIPU_S_VEC_HI;
          end
        end
        MIPU_S_VEC_HI: st_ff <= MIPU_S_VEC_LO;
        MIPU_S_VEC_LO: st_ff <= MIPU_S_VEC_END;
        MIPU_S_VEC_END: st_ff <= MIPU_S_IDLE;
        MIPU_S_POP: begin
          idx_ff <= idx_ff + 3'h1;
          if (idx_ff == MIPU_STK_LAST) begin
            st_ff <= MIPU_S_RET_END;
          end
        end
        default: st_ff <= MIPU_S_IDLE;
      endcase
    end
  end

  // byte order PCL, PCH, X, A, CCR
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      for (int i = 0; i < 5; i++) begin
        stk_ff[i] <= 8'h00;
      end
    end else if (st_ff == MIPU_S_IDLE && INSTR_DONE) begin
      stk_ff[0] <= CPU_REGS.pc[7:0];
      stk_ff[1] <= CPU_REGS.pc[15:8];
      stk_ff[2] <= CPU_REGS.x;
      stk_ff[3] <= CPU_REGS.a;
      stk_ff[4] <= CPU_REGS.ccr;
    end
  end

  // Stack pointer: post-decrement on push, pre-increment on pop
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sp_ff <= MIPU_SP_RESET;
    end else if (rst_req) begin
      sp_ff <= MIPU_SP_RESET;
    end else if (st_ff == MIPU_S_IDLE) begin
      sp_ff <= CPU_REGS.sp;
    end else if (st_ff == MIPU_S_PUSH) begin
      sp_ff <= sp_ff - 8'h01;
    end else if (st_ff == MIPU_S_POP) begin
      sp_ff <= sp_ff + 8'h01;
    end
  end

  // Memory strobes straight from state and flops
  always_comb begin
    MEM_WR = (st_ff == MIPU_S_PUSH);
    MEM_RD = (st_ff == MIPU_S_VEC_HI) || (st_ff == MIPU_S_VEC_LO) || (st_ff == MIPU_S_POP);
    MEM_WDATA = (st_ff == MIPU_S_PUSH) ? stk_ff[idx_ff] : 8'h00;
    if (st_ff == MIPU_S_PUSH) begin
      MEM_ADDR = {MIPU_STACK_PAGE, sp_ff};
    end else if (st_ff == MIPU_S_POP) begin
      MEM_ADDR = {MIPU_STACK_PAGE, sp_ff + 8'h01};
    end else if (st_ff == MIPU_S_VEC_HI) begin
      MEM_ADDR = vec_addr;
    end else if (st_ff == MIPU_S_VEC_LO) begin
      MEM_ADDR = vec_addr + 16'h0001;
    end else begin
      MEM_ADDR = 16'h0000;
    end
  end
  assign BUSY = (st_ff != MIPU_S_IDLE);

  // mask bit set on entry load
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      vec_hi_ff <= 8'h00;
      rd_pend_ff <= 1'b0;
      rd_idx_ff <= 3'h0;
      entry_load_ff <= 1'b0;
      return_load_ff <= 1'b0;
      regs_out_ff <= '0;
    end else begin
      rd_pend_ff <= (st_ff == MIPU_S_POP);
      rd_idx_ff <= idx_ff;
      entry_load_ff <= (st_ff == MIPU_S_VEC_END);
      return_load_ff <= (st_ff == MIPU_S_RET_END);
      if (st_ff == MIPU_S_VEC_LO) begin
        vec_hi_ff <= MEM_RDATA;
      end
      if (st_ff == MIPU_S_VEC_END) begin
        regs_out_ff.pc <= {vec_hi_ff, MEM_RDATA};
        regs_out_ff.ccr <= (src_ff == MIPU_SRC_RESET) ? MIPU_CCR_I_MASK :
          (stk_ff[4] | MIPU_CCR_I_MASK);
        regs_out_ff.sp <= sp_ff;
      end
      if (rd_pend_ff) begin
        case (rd_idx_ff)
          3'h0: regs_out_ff.ccr <= MEM_RDATA;
          3'h1: regs_out_ff.a <= MEM_RDATA;
          3'h2: regs_out_ff.x <= MEM_RDATA;
          3'h3: regs_out_ff.pc[15:8] <= MEM_RDATA;
          default: regs_out_ff.pc[7:0] <= MEM_RDATA;
        endcase
      end
      if (st_ff == MIPU_S_RET_END) begin
        regs_out_ff.sp <= sp_ff;
      end
    end
  end
  assign ENTRY_LOAD = entry_load_ff;
  assign RETURN_LOAD = return_load_ff;
  assign REGS_OUT = regs_out_ff;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  chk_entry_boundary: assert property (
    (st_ff == MIPU_S_PUSH && idx_ff == 3'h0) |-> $past(INSTR_DONE))
    else $error("entry started without instruction done");
  chk_push_then_vec: assert property (
    (MEM_WR && idx_ff == 3'h0 && !rst_req) |-> MEM_WR[*5] ##1 (MEM_RD && MEM_ADDR == vec_addr))
    else $error("stacking did not precede vector fetch");
  chk_ext_vector: assert property (
    (st_ff == MIPU_S_VEC_HI && src_ff == MIPU_SRC_EXT) |-> MEM_ADDR == MIPU_VEC_EXT)
    else $error("external vector address wrong");
  chk_ext_priority: assert property (
    (st_ff == MIPU_S_IDLE && INSTR_DONE && !RETURN_FROM_TRAP_INSTR && !SOFT_TRAP_INSTR &&
      ext_req && !rst_req)
    |=> src_ff == MIPU_SRC_EXT)
    else $error("priority order broken");
  chk_mask_set: assert property (
    (st_ff == MIPU_S_VEC_END && !rst_req) |=> ENTRY_LOAD && REGS_OUT.ccr[MIPU_CCR_I_POS])
    else $error("mask bit not set on entry");
  chk_return_pops: assert property (
    (st_ff == MIPU_S_IDLE && INSTR_DONE && RETURN_FROM_TRAP_INSTR && !rst_req)
    |=> (MEM_RD && !rst_req)[*5] ##1 !MEM_RD ##1 RETURN_LOAD)
    else $error("return sequence wrong");
  // soft trap goes through its own pair
  chk_trap_vector: assert property (
    (st_ff == MIPU_S_VEC_HI && src_ff == MIPU_SRC_SOFT_TRAP) |-> MEM_ADDR == MIPU_VEC_SOFT_TRAP)
    else $error("soft trap vector wrong");
  chk_ext_gated: assert property (
    (st_ff == MIPU_S_PUSH && idx_ff == 3'h0 && src_ff == MIPU_SRC_EXT)
    |-> $past(EXT_IRQ_ENABLE) && !$past(i_bit))
    else $error("external taken while inhibited");
  chk_wdog_gated: assert property (
    (st_ff == MIPU_S_IDLE && WATCHDOG_TIMEOUT && !WATCHDOG_OPTION && !RESET_REQ && !INSTR_DONE)
    |=> st_ff == MIPU_S_IDLE)
    else $error("watchdog acted while disabled");
  chk_latch_clear: assert property (
    (st_ff == MIPU_S_VEC_HI && src_ff == MIPU_SRC_EXT && !ext_set) |=> !ext_latch_ff)
    else $error("external latch not cleared at fetch");
  chk_edge_latch: assert property (
    $rose(ext_level) |=> ext_latch_ff)
    else $error("request edge not latched");

endmodule

// ==== verilog/mipu_pkg.sv ====
// Shared constants and carrier types for the interrupt priority unit
package mipu_pkg;

  // Vector pair base addresses, high byte first
  localparam logic [15:0] MIPU_VEC_RESET = 16'h1FFE;
  localparam logic [15:0] MIPU_VEC_SOFT_TRAP = 16'h1FFC;
  localparam logic [15:0] MIPU_VEC_EXT = 16'h1FFA;
  localparam logic [15:0] MIPU_VEC_CTIM = 16'h1FF8;
  localparam logic [15:0] MIPU_VEC_PTIM = 16'h1FF6;
  localparam logic [15:0] MIPU_VEC_SER = 16'h1FF4;
  localparam logic [15:0] MIPU_VEC_ANA = 16'h1FF2;

  // Stack lives in this page; pointer value after reset
  localparam logic [7:0] MIPU_STACK_PAGE = 8'h00;
  localparam logic [7:0] MIPU_SP_RESET = 8'hFF;

  // Condition code field position of the global mask bit
  localparam int MIPU_CCR_I_POS = 3;
  localparam logic [7:0] MIPU_CCR_I_MASK = 8'h08;

  // Last index of the stacked bytes
  localparam logic [2:0] MIPU_STK_LAST = 3'h4;

  // Pin synchroniser: idle levels of {port A pins, external pin}
  localparam logic [4:0] MIPU_PIN_IDLE = 5'h01;

  typedef enum logic [2:0] {
    MIPU_SRC_RESET = 3'h0,
    MIPU_SRC_SOFT_TRAP = 3'h1,
    MIPU_SRC_EXT = 3'h2,
    MIPU_SRC_CTIM = 3'h3,
    MIPU_SRC_PTIM = 3'h4,
    MIPU_SRC_SER = 3'h5,
    MIPU_SRC_ANA = 3'h6
  } mipu_src_t;

  typedef enum logic [2:0] {
    MIPU_S_IDLE = 3'h0,
    MIPU_S_PUSH = 3'h1,
    MIPU_S_VEC_HI = 3'h2,
    MIPU_S_VEC_LO = 3'h3,
    MIPU_S_VEC_END = 3'h4,
    MIPU_S_POP = 3'h5,
    MIPU_S_RET_END = 3'h6
  } mipu_state_t;

  // CPU register set as stacked or restored
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [7:0] ccr;
    logic [7:0] sp;
  } mipu_regs_t;

  // Peripheral interrupt flags
  typedef struct packed {
    logic core_timer_overflow_flag;
    logic periodic_tick_flag;
    logic capture_flag;
    logic compare_flag;
    logic timer_overflow_flag;
    logic serial_done_flag;
    logic comparator1_flag;
    logic comparator2_flag;
  } mipu_flags_t;

  // Local software enables
  typedef struct packed {
    logic core_overflow_enable;
    logic periodic_tick_enable;
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic timer_overflow_enable;
    logic serial_irq_enable;
    logic comparator_irq_enable;
  } mipu_enables_t;

endpackage

// ==== dv/mipu_mem_model.sv ====
// Memory model: vector table and stack page behind the priority unit
`timescale 1ns/100ps
module mipu_mem_model
  import mipu_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic [15:0] mem_addr, // Address
  input wire logic mem_rd, // Read strobe
  input wire logic mem_wr, // Write strobe
  input wire logic [7:0] mem_wdata, // Write data
  output logic [7:0] mem_rdata // Read data, one cycle after strobe
);
  logic [7:0] mem_ff [0:65535];
  logic [15:0] vecs [7] = '{MIPU_VEC_RESET, MIPU_VEC_SOFT_TRAP, MIPU_VEC_EXT, MIPU_VEC_CTIM,
                            MIPU_VEC_PTIM, MIPU_VEC_SER, MIPU_VEC_ANA};
  // Vector pair holds C0 then the base low byte, so each source is told apart
  initial begin
    for (int i = 0; i < 7; i++) begin
      mem_ff[vecs[i]] = 8'hC0;
      mem_ff[vecs[i] + 16'h0001] = vecs[i][7:0];
    end
  end
  // Idle cycles show a changing value so a late sample never looks right
  always @(posedge mclk) begin
    if (mem_wr) mem_ff[mem_addr] <= mem_wdata;
    mem_rdata <= mem_rd ? mem_ff[mem_addr] : ~mem_rdata;
  end
endmodule

// ==== dv/test_mipu_core.sv ====
// Self-checking bench for the interrupt priority unit
`timescale 1ns/100ps
module test_mipu_core;
  import mipu_pkg::*;
  logic mclk = 0, reset = 1, instr_done = 0, soft_trap_instr = 0, return_from_trap_instr = 0;
  logic irq_pin_n = 1, ext_irq_enable = 1, ext_flag_clear = 0, port_irq_option = 0;
  logic level_sense_option = 0, watchdog_option = 0, watchdog_timeout = 0, reset_req = 0;
  logic [3:0] port_a_irq_pins = 4'h0;
  mipu_regs_t regs = '{16'h1234, 8'h56, 8'h78, 8'h00, 8'hF0};
  mipu_regs_t orig = '{16'h1234, 8'h56, 8'h78, 8'h00, 8'hF0};
  mipu_flags_t flags = '0;
  mipu_enables_t ens = '1;
  logic [7:0] mem_rdata, mem_wdata;
  logic [15:0] mem_addr;
  logic mem_rd, mem_wr, busy, entry_load, return_load, ext_irq_flag;
  mipu_regs_t regs_out;
  logic [15:0] vecs [5] = '{MIPU_VEC_EXT, MIPU_VEC_CTIM, MIPU_VEC_PTIM, MIPU_VEC_SER,
                            MIPU_VEC_ANA};
  int n_errors = 0, check_count = 0;

  always #12.5 mclk = ~mclk;

  mipu_core u_dut (.MCLK(mclk), .RESET(reset), .INSTR_DONE(instr_done),
    .SOFT_TRAP_INSTR(soft_trap_instr), .RETURN_FROM_TRAP_INSTR(return_from_trap_instr),
    .CPU_REGS(regs), .PERIPH_FLAGS(flags),
    .PERIPH_ENABLES(ens), .IRQ_PIN_N(irq_pin_n), .PORT_A_IRQ_PINS(port_a_irq_pins),
    .EXT_IRQ_ENABLE(ext_irq_enable), .EXT_FLAG_CLEAR(ext_flag_clear),
    .PORT_IRQ_OPTION(port_irq_option), .LEVEL_SENSE_OPTION(level_sense_option),
    .WATCHDOG_OPTION(watchdog_option), .WATCHDOG_TIMEOUT(watchdog_timeout),
    .RESET_REQ(reset_req), .MEM_RDATA(mem_rdata), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
    .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .BUSY(busy), .ENTRY_LOAD(entry_load),
    .RETURN_LOAD(return_load), .REGS_OUT(regs_out), .EXT_IRQ_FLAG(ext_irq_flag));

  mipu_mem_model u_mem (.mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One boundary request, taken at the edge where the task returns
  task automatic boundary(input logic trap, input logic ret);
    @(posedge mclk);
    instr_done <= 1'b1;
    soft_trap_instr <= trap;
    return_from_trap_instr <= ret;
    @(posedge mclk);
    instr_done <= 1'b0;
    soft_trap_instr <= 1'b0;
    return_from_trap_instr <= 1'b0;
  endtask

  // Bounded wait for a load pulse; counts a miss when it never comes
  task automatic wait_load(input logic ret);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      #1;
      if ((ret ? return_load : entry_load) === 1'b1) break;
    end
    chk(i < 20, 1'b1);
  endtask

  // Sequencer must stay idle: the request was refused
  task automatic quiet();
    repeat (4) begin
      #1 chk(busy, 1'b0);
      @(posedge mclk);
    end
  endtask

  // Entry result: vector, mask set, five bytes pushed at sp downward
  task automatic entry(input logic [15:0] vec);
    logic [39:0] stk;
    stk = {regs.pc[7:0], regs.pc[15:8], regs.x, regs.a, regs.ccr};
    wait_load(1'b0);
    chk(regs_out.pc, {8'hC0, vec[7:0]});
    chk(regs_out.ccr, regs.ccr | MIPU_CCR_I_MASK);
    chk(regs_out.sp, regs.sp - 8'h05);
    for (int j = 0; j < 5; j++) begin
      chk(u_mem.mem_ff[{MIPU_STACK_PAGE, regs.sp - 8'(j)}], stk[39 - 8 * j -: 8]);
    end
  endtask

  task automatic reset_entry();
    wait_load(1'b0);
    chk(regs_out, {16'hC0FE, regs_out.x, regs_out.a, 8'h08, MIPU_SP_RESET});
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #(25 * 6000);
    n_errors++;
    report_and_stop();
  end

  initial begin
    cyc(6);
    reset <= 1'b0;
    reset_entry();
    $display("test reset done");
    // Sources k and below all pending; the highest one wins
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk);
      irq_pin_n <= !(k == 0);
      flags.core_timer_overflow_flag <= (k <= 1);
      flags.capture_flag <= (k <= 2);
      flags.serial_done_flag <= (k <= 3);
      flags.comparator1_flag <= 1'b1;
      cyc(8);
      quiet();
      boundary(1'b0, 1'b0);
      entry(vecs[k]);
      chk(ext_irq_flag, 1'b0);
      // Flags stay up until cleared, so service code can poll the group
      // group flags polled
      @(posedge mclk);
      flags <= '0;
      irq_pin_n <= 1'b1;
      regs.sp <= orig.sp - 8'h05;
      boundary(1'b0, 1'b1);
      wait_load(1'b1);
      chk(regs_out, orig);
      @(posedge mclk);
      regs <= orig;
    end
    $display("test priority done");
    // Masked: hardware source refused, soft trap still enters
    @(posedge mclk);
    regs.ccr <= MIPU_CCR_I_MASK;
    flags.comparator2_flag <= 1'b1;
    boundary(1'b0, 1'b0);
    quiet();
    boundary(1'b1, 1'b0);
    entry(MIPU_VEC_SOFT_TRAP);
    @(posedge mclk);
    flags <= '0;
    regs <= orig;
    $display("test mask done");
    // Port pins join the external latch only with the option on
    @(posedge mclk);
    port_a_irq_pins <= 4'h4;
    cyc(8);
    #1 chk(ext_irq_flag, 1'b0);
    // Pins settle low before the option joins them, so only a real pin edge can set the latch
    @(posedge mclk);
    port_a_irq_pins <= 4'h0;
    cyc(6);
    port_irq_option <= 1'b1;
    cyc(6);
    #1 chk(ext_irq_flag, 1'b0);
    @(posedge mclk);
    port_a_irq_pins <= 4'h2;
    cyc(8);
    #1 chk(ext_irq_flag, 1'b1);
    @(posedge mclk);
    ext_irq_enable <= 1'b0;
    boundary(1'b0, 1'b0);
    quiet();
    @(posedge mclk);
    ext_irq_enable <= 1'b1;
    regs.ccr <= MIPU_CCR_I_MASK;
    boundary(1'b0, 1'b0);
    quiet();
    @(posedge mclk);
    port_a_irq_pins <= 4'h0;
    port_irq_option <= 1'b0;
    regs <= orig;
    ext_flag_clear <= 1'b1;
    @(posedge mclk);
    ext_flag_clear <= 1'b0;
    $display("test port done");
    // Level option: a held low pin sets the latch again after a clear
    for (int lv = 1; lv >= 0; lv--) begin
      @(posedge mclk);
      level_sense_option <= lv[0];
      irq_pin_n <= 1'b0;
      cyc(8);
      #1 chk(ext_irq_flag, 1'b1);
      @(posedge mclk);
      ext_flag_clear <= 1'b1;
      @(posedge mclk);
      ext_flag_clear <= 1'b0;
      cyc(4);
      #1 chk(ext_irq_flag, lv[0]);
      // Pin back high and settled before the clear, so the next falling edge is a fresh one
      @(posedge mclk);
      irq_pin_n <= 1'b1;
      cyc(8);
      ext_flag_clear <= 1'b1;
      @(posedge mclk);
      ext_flag_clear <= 1'b0;
    end
    $display("test level done");
    // Watchdog counts only when optioned; other reset sources always
    for (int w = 0; w < 3; w++) begin
      @(posedge mclk);
      watchdog_option <= (w == 1);
      watchdog_timeout <= (w < 2);
      reset_req <= (w == 2);
      @(posedge mclk);
      watchdog_timeout <= 1'b0;
      reset_req <= 1'b0;
      if (w == 0) quiet();
      else reset_entry();
    end
    $display("test watchdog done");
    report_and_stop();
  end
endmodule
